/* src/ats_trigger_sequencer.sv */
// Notes on behaviour
// - Result is round(vin/vref*4096), the comparator threshold sets rounding.
// - Four modes: software or timer trigger, continuous or single.
// - Software mode: writing start bit 1 converts the selected channel.
// - Each completion stores word and high byte, pulses done interrupt.
// - Continuous mode starts the next conversion at once.
// - Single mode clears the start bit after one conversion, then idles.
// - Software mode: start bit 1 while busy restarts, result kept.
// - Channel write while busy restarts, except timer single mode.
// - Software mode: start bit 0 while busy stops, result kept.
// - Timer select bit set puts block into trigger waiting.
// - A timer trigger sets start bit and converts current channel.
// - Timer trigger while busy restarts conversion, result kept.
// - Timer continuous: start bit 0 stops and waits for trigger.
// - Timer single: channel write waits for next conversion start.
// - Clearing timer select with start bit 0 returns to software.
// - Reset clears word and high byte result registers to zero.
// - Bits resolved one at a time, most significant first.
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module ats_trigger_sequencer #(
   parameter int SAMPLE_CYC = ats_pkg::DEF_SAMPLE_CYC,
   parameter int SETTLE_CYC = ats_pkg::DEF_SETTLE_CYC
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire ats_pkg::ats_word_t hwdata,
   input  wire logic               hready,
   output ats_pkg::ats_word_t      hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               timer_trigger,
   input  wire logic               cmp_ge_pin,
   output ats_pkg::ats_chan_t      analog_input_channel,
   output ats_pkg::ats_code_t      trial_code,
   output logic                    sample_hold_en,
   output logic                    conversion_done_irq
);
   import ats_pkg::*;

   // ==========================================================
   // Block state
   typedef struct packed {
      logic              start;
      logic              cont;
      logic              tmr_sel;
      ats_chan_t         chan;
      ats_code_t         res_word;
      ats_high_t         res_high;
      logic              wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      ats_word_t         rdata;
      logic [2:0]        cmp_sync;
      logic              cmp;
      logic              irq;
   } ats_ctl_state_t;

   localparam ats_ctl_state_t CTL_RESET = '{
      res_word: RESULT_RESET,
      res_high: HIGH_RESET,
      default:  '0
   };

   ats_ctl_state_t st_q;
   ats_ctl_state_t st_d;

   logic      go;
   logic      stop;
   logic      acc;
   logic      eng_busy;
   logic      eng_done;
   ats_code_t eng_result;
   ats_chan_t eng_chan;
   logic      eng_hold;
   ats_code_t eng_trial;

   // ==========================================================
   // Read decode
   function automatic ats_word_t read_word(
      input logic [ADDR_W-1:0] addr,
      input ats_ctl_state_t    s,
      input logic              busy
   );
      ats_word_t rd;
      rd = '0;
      unique case (addr)
         OFS_MODE: begin
            rd[START_BIT] = s.start;
            rd[CONT_BIT]  = s.cont;
         end
         OFS_MODE_TWO: begin
            rd[TMR_SEL_BIT] = s.tmr_sel;
         end
         OFS_CHAN: begin
            rd[CH_W-1:0] = s.chan;
         end
         OFS_RESULT_WORD: begin
            rd[RES_W-1:0] = s.res_word;
         end
         OFS_RESULT_HIGH: begin
            rd[HIGH_W-1:0] = s.res_high;
         end
         OFS_STATUS: begin
            rd[BUSY_BIT] = busy;
         end
         default: begin
            rd = '0;
         end
      endcase
      return rd;
   endfunction : read_word

   // ==========================================================
   // Next state and engine commands
   always_comb begin
      st_d     = st_q;
      st_d.irq = 1'b0;
      go       = 1'b0;
      stop     = 1'b0;

      // Address phase capture, zero wait states
      acc = hsel && htrans[HTRANS_ACT_BIT] && hready
            && (hsize == HSIZE_WORD);
      st_d.wr_pend = acc && hwrite;
      if (acc) begin
         st_d.wr_addr = haddr[ADDR_W-1:0];
      end
      if (acc && !hwrite) begin
         st_d.rdata = read_word(haddr[ADDR_W-1:0], st_q, eng_busy);
      end

      // Comparator synchroniser, change taken when stages agree
      st_d.cmp_sync = {st_q.cmp_sync[1:0], cmp_ge_pin};
      if (st_q.cmp_sync[1] == st_q.cmp_sync[2]) begin
         st_d.cmp = st_q.cmp_sync[2];
      end

      // Completion: latch result, pulse interrupt, chain or idle
      if (eng_done) begin
         st_d.res_word = eng_result;
         st_d.res_high = eng_result[RES_W-1 -: HIGH_W];
         st_d.irq      = 1'b1;
         if (st_q.cont && st_q.start) begin
            go = 1'b1;
         end else begin
            st_d.start = 1'b0;
         end
      end

      // Register writes in the data phase
      if (st_q.wr_pend) begin
         unique case (st_q.wr_addr)
            OFS_MODE: begin
               st_d.cont = hwdata[CONT_BIT];
               if (!st_q.tmr_sel) begin
                  st_d.start = hwdata[START_BIT];
                  if (hwdata[START_BIT]) begin
                     go = 1'b1;
                  end else begin
                     go   = 1'b0;
                     stop = 1'b1;
                  end
               end else if (!hwdata[START_BIT]) begin
                  st_d.start = 1'b0;
                  go         = 1'b0;
                  stop       = 1'b1;
               end
            end
            OFS_MODE_TWO: begin
               if (hwdata[TMR_SEL_BIT] || !st_q.start) begin
                  st_d.tmr_sel = hwdata[TMR_SEL_BIT];
               end
            end
            OFS_CHAN: begin
               st_d.chan = hwdata[CH_W-1:0];
               if ((eng_busy || go)
                   && !(st_q.tmr_sel && !st_q.cont)) begin
                  go   = 1'b1;
                  stop = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Timer trigger wins over any clear in the same cycle
      if (timer_trigger && st_q.tmr_sel) begin
         st_d.start = 1'b1;
         go         = 1'b1;
         stop       = 1'b0;
      end
   end

   // State register, results cleared by reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= CTL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Conversion engine
   ats_conv_engine #(
      .SAMPLE_CYC (SAMPLE_CYC),
      .SETTLE_CYC (SETTLE_CYC)
   ) u_engine (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .go         (go),
      .stop       (stop),
      .chan_in    (st_d.chan),
      .cmp_ge     (st_q.cmp),
      .busy       (eng_busy),
      .done       (eng_done),
      .trial_code (eng_trial),
      .result     (eng_result),
      .chan_out   (eng_chan),
      .hold       (eng_hold)
   );

   // Outputs
   assign hrdata               = st_q.rdata;
   assign hreadyout            = 1'b1;
   assign hresp                = 1'b0;
   assign analog_input_channel = eng_chan;
   assign trial_code           = eng_trial;
   assign sample_hold_en       = eng_hold;
   assign conversion_done_irq  = st_q.irq;

   // ==========================================================
   // Checks
   logic      wr_mode;
   logic      wr_mode_two;
   logic      wr_chan;
   logic      wr_start_val;
   logic      wr_tmr_val;
   ats_chan_t wr_chan_val;
   logic      trig_sel;

   assign wr_mode      = st_q.wr_pend && (st_q.wr_addr == OFS_MODE);
   assign wr_mode_two  = st_q.wr_pend && (st_q.wr_addr == OFS_MODE_TWO);
   assign wr_chan      = st_q.wr_pend && (st_q.wr_addr == OFS_CHAN);
   assign wr_start_val = hwdata[START_BIT];
   assign wr_tmr_val   = hwdata[TMR_SEL_BIT];
   assign wr_chan_val  = hwdata[CH_W-1:0];
   assign trig_sel     = timer_trigger && st_q.tmr_sel;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_store_on_done: assert property (
      eng_done |=> (st_q.res_word == $past(eng_result))
                   && conversion_done_irq)
      else $error("Result not stored on completion");

   a_high_byte_pair: assert property (
      $changed(st_q.res_word) |-> $past(eng_done)
         && (st_q.res_high == st_q.res_word[RES_W-1 -: HIGH_W]))
      else $error("High byte not paired with word result");

   a_cont_chain: assert property (
      eng_done && st_q.cont && st_q.start && !st_q.wr_pend
      |=> eng_busy && !sample_hold_en)
      else $error("Continuous mode did not chain");

   a_single_idle: assert property (
      eng_done && !st_q.cont && !st_q.wr_pend && !trig_sel
      |=> !st_q.start && !eng_busy)
      else $error("Single mode did not clear start");

   a_sw_start: assert property (
      wr_mode && wr_start_val && !st_q.tmr_sel && !eng_busy
      |=> st_q.start && eng_busy && !sample_hold_en
          && (eng_chan == st_q.chan))
      else $error("Software start failed");

   a_sw_restart: assert property (
      wr_mode && wr_start_val && !st_q.tmr_sel && eng_busy && !eng_done
      |=> eng_busy && !sample_hold_en && $stable(st_q.res_word))
      else $error("Software restart lost result or did not restart");

   a_sw_stop: assert property (
      wr_mode && !wr_start_val && !st_q.tmr_sel && !eng_done
      |=> !eng_busy && !st_q.start && $stable(st_q.res_word))
      else $error("Software stop failed");

   a_chan_abort: assert property (
      wr_chan && eng_busy && !eng_done && !(st_q.tmr_sel && !st_q.cont)
      |=> eng_busy && (eng_chan == $past(wr_chan_val))
          && !sample_hold_en && $stable(st_q.res_word))
      else $error("Channel write did not restart");

   a_tmr_single_keep: assert property (
      wr_chan && eng_busy && st_q.tmr_sel && !st_q.cont && !trig_sel
      |=> $stable(eng_chan))
      else $error("Channel changed during timer single conversion");

   a_trig_start: assert property (
      trig_sel && !eng_done
      |=> st_q.start && eng_busy && !sample_hold_en
          && $stable(st_q.res_word))
      else $error("Trigger did not start conversion");

   a_trig_ignored: assert property (
      timer_trigger && !st_q.tmr_sel && !eng_busy && !st_q.wr_pend
      |=> !eng_busy)
      else $error("Unselected trigger started conversion");

   a_tmr_stop: assert property (
      wr_mode && !wr_start_val && st_q.tmr_sel && !trig_sel
      |=> !eng_busy && st_q.tmr_sel && !st_q.start)
      else $error("Timer mode stop failed");

   a_tmr_sel_write: assert property (
      wr_mode_two && !st_q.start
      |=> st_q.tmr_sel == $past(wr_tmr_val))
      else $error("Timer select write not applied");

   a_msb_first: assert property (
      $rose(sample_hold_en) |-> trial_code == MSB_CODE)
      else $error("First trial is not the top bit");

   c_cont_done: cover property (
      eng_done && st_q.cont ##1 eng_busy);
   c_single_done: cover property (
      eng_done && !st_q.cont ##1 !st_q.start);
   c_trig_restart: cover property (
      trig_sel && eng_busy);
   c_chan_abort: cover property (
      wr_chan && eng_busy && !st_q.tmr_sel);
endmodule : ats_trigger_sequencer
`default_nettype wire

/* src/ats_pkg.sv */
`default_nettype none
package ats_pkg;
   // ==========================================================
   // Widths
   localparam int RES_W     = 12;
   localparam int HIGH_W    = 8;
   localparam int CH_W      = 4;
   localparam int BIT_IDX_W = 4;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;

   typedef logic [RES_W-1:0]  ats_code_t;
   typedef logic [HIGH_W-1:0] ats_high_t;
   typedef logic [CH_W-1:0]   ats_chan_t;
   typedef logic [DATA_W-1:0] ats_word_t;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_MODE        = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MODE_TWO    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CHAN        = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RESULT_WORD = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h14;

   // ==========================================================
   // Field positions
   localparam int START_BIT   = 7;
   localparam int CONT_BIT    = 6;
   localparam int TMR_SEL_BIT = 7;
   localparam int BUSY_BIT    = 0;

   // ==========================================================
   // Reset values and codes
   localparam ats_code_t RESULT_RESET = 12'h000;
   localparam ats_high_t HIGH_RESET   = 8'h00;
   localparam ats_code_t MSB_CODE     = 12'h800;

   // ==========================================================
   // Bus encodings
   localparam int         HTRANS_ACT_BIT = 1;
   localparam logic [2:0] HSIZE_WORD     = 3'h2;

   // ==========================================================
   // Timing in clock cycles
   localparam int DEF_SAMPLE_CYC = 8;
   localparam int DEF_SETTLE_CYC = 8;
   localparam int MIN_SETTLE_CYC = 5;

   typedef enum logic [1:0] {
      ATS_IDLE,
      ATS_SAMPLE,
      ATS_TRIAL
   } ats_eng_st_t;
endpackage : ats_pkg
`default_nettype wire

/* src/ats_conv_engine.sv */
`timescale 1ns/10ps
`default_nettype none
module ats_conv_engine #(
   parameter int SAMPLE_CYC = ats_pkg::DEF_SAMPLE_CYC,
   parameter int SETTLE_CYC = ats_pkg::DEF_SETTLE_CYC
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              go,
   input  wire logic              stop,
   input  wire ats_pkg::ats_chan_t chan_in,
   input  wire logic              cmp_ge,
   output logic                   busy,
   output logic                   done,
   output ats_pkg::ats_code_t     trial_code,
   output ats_pkg::ats_code_t     result,
   output ats_pkg::ats_chan_t     chan_out,
   output logic                   hold
);
   import ats_pkg::*;

   localparam int CNT_MAX = (SAMPLE_CYC > SETTLE_CYC) ? SAMPLE_CYC
                                                      : SETTLE_CYC;
   localparam int CNT_W   = $clog2(CNT_MAX + 1);

   // ==========================================================
   // Parameter checks
   if (SAMPLE_CYC < 1) begin : g_chk_sample
      $error("Sample time must be at least one cycle");
   end
   if (SETTLE_CYC < MIN_SETTLE_CYC) begin : g_chk_settle
      $error("Settle time shorter than comparator sync delay");
   end

   typedef struct packed {
      ats_eng_st_t          st;
      logic [CNT_W-1:0]     cnt;
      logic [BIT_IDX_W-1:0] bit_idx;
      ats_code_t            approx;
      ats_code_t            result;
      ats_chan_t            chan;
      logic                 hold;
      logic                 done;
   } ats_eng_state_t;

   localparam ats_eng_state_t ENG_RESET = '{st: ATS_IDLE, default: '0};

   ats_eng_state_t st_q;
   ats_eng_state_t st_d;

   // ==========================================================
   // Sample, hold, then one trial per bit from the top down
   always_comb begin
      st_d      = st_q;
      st_d.done = 1'b0;
      if (go) begin
         st_d.st   = ATS_SAMPLE;
         st_d.cnt  = '0;
         st_d.chan = chan_in;
         st_d.hold = 1'b0;
      end else if (stop) begin
         st_d.st   = ATS_IDLE;
         st_d.cnt  = '0;
         st_d.hold = 1'b0;
      end else begin
         unique case (st_q.st)
            ATS_IDLE: begin
            end
            ATS_SAMPLE: begin
               if (st_q.cnt == CNT_W'(SAMPLE_CYC - 1)) begin
                  st_d.st      = ATS_TRIAL;
                  st_d.cnt     = '0;
                  st_d.hold    = 1'b1;
                  st_d.bit_idx = BIT_IDX_W'(RES_W - 1);
                  st_d.approx  = MSB_CODE;
               end else begin
                  st_d.cnt = st_q.cnt + 1'b1;
               end
            end
            ATS_TRIAL: begin
               if (st_q.cnt == CNT_W'(SETTLE_CYC - 1)) begin
                  st_d.cnt                 = '0;
                  st_d.approx[st_q.bit_idx] = cmp_ge;
                  if (st_q.bit_idx == '0) begin
                     st_d.result = st_d.approx;
                     st_d.done   = 1'b1;
                     st_d.st     = ATS_IDLE;
                     st_d.hold   = 1'b0;
                  end else begin
                     st_d.bit_idx = st_q.bit_idx - 1'b1;
                     st_d.approx[st_q.bit_idx - 1'b1] = 1'b1;
                  end
               end else begin
                  st_d.cnt = st_q.cnt + 1'b1;
               end
            end
            default: begin
               st_d.st = ATS_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ENG_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs
   assign busy       = (st_q.st != ATS_IDLE);
   assign done       = st_q.done;
   assign trial_code = st_q.approx;
   assign result     = st_q.result;
   assign chan_out   = st_q.chan;
   assign hold       = st_q.hold;
endmodule : ats_conv_engine
`default_nettype wire

/* tb/ats_front_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ats_front_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic [15:0][13:0]  vin_half,
   input  wire ats_pkg::ats_chan_t channel,
   input  wire ats_pkg::ats_code_t trial_code,
   input  wire logic               sample_hold_en,
   input  wire logic               fire,
   output logic                    cmp_ge_pin,
   output logic                    timer_trigger
);
   import ats_pkg::*;

   logic [13:0] held_q;

   // ==========================================================
   // Sample and hold: tracks the selected input, freezes on hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held_q <= 14'h0000;
      end else if (!sample_hold_en) begin
         held_q <= vin_half[channel];
      end
   end

   // Comparator in half steps: input at least tap minus half a step
   always_comb begin
      cmp_ge_pin = ({1'b0, held_q}
                    >= ({2'h0, trial_code, 1'b0} - 15'h0001));
   end

   // Trigger source: one pulse per request, spacing kept by the bench
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_trigger <= 1'b0;
      end else begin
         timer_trigger <= fire;
      end
   end
endmodule : ats_front_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ats_pkg::*;

   typedef struct packed {
      ats_chan_t   ch;
      logic [13:0] vin;
      ats_code_t   code;
   } ats_row_t;

   // ==========================================================
   // Signals
   logic              hclk       = 1'b0;
   logic              hresetn    = 1'b0;
   logic              hsel       = 1'b0;
   logic [31:0]       haddr      = 32'h0;
   logic [1:0]        htrans     = 2'h0;
   logic              hwrite     = 1'b0;
   logic [2:0]        hsize      = HSIZE_WORD;
   ats_word_t         hwdata     = 32'h0;
   logic              fire       = 1'b0;
   logic [15:0][13:0] vin_half   = '0;
   ats_word_t         hrdata;
   logic              hreadyout;
   logic              hresp;
   logic              trig;
   logic              cmp_ge;
   ats_chan_t         chan;
   ats_code_t         trial;
   logic              hold;
   logic              irq;
   int                fail_count = 0;
   int                checks     = 0;
   int                cycles     = 0;
   int                n;
   ats_row_t          rows [6]   = '{'{4'h0, 14'd0, 12'h000},
      '{4'h3, 14'd1, 12'h001}, '{4'h5, 14'd4094, 12'h7ff},
      '{4'h9, 14'd4095, 12'h800}, '{4'hf, 14'd8190, 12'hfff},
      '{4'ha, 14'd2731, 12'h556}};

   ats_trigger_sequencer #(.SAMPLE_CYC(1), .SETTLE_CYC(5))
   ats_trigger_sequencer_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .timer_trigger(trig), .cmp_ge_pin(cmp_ge),
      .analog_input_channel(chan), .trial_code(trial),
      .sample_hold_en(hold), .conversion_done_irq(irq)
   );

   ats_front_model ats_front_model_i (
      .hclk(hclk), .hresetn(hresetn), .vin_half(vin_half),
      .channel(chan), .trial_code(trial), .sample_hold_en(hold),
      .fire(fire), .cmp_ge_pin(cmp_ge), .timer_trigger(trig)
   );

   // ==========================================================
   // Clock and hang guard
   always #10 hclk = ~hclk;

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end

   // ==========================================================
   // Tasks
   task automatic close_out();
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic check(input ats_word_t seen, input ats_word_t exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // One single AHB transfer, entered just after a rising edge
   task automatic xfer(input logic wr_en, input logic [7:0] a,
                       input ats_word_t d, output ats_word_t q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr_en;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input ats_word_t d);
      ats_word_t q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input ats_word_t exp);
      ats_word_t q;
      xfer(1'b0, a, 32'h0, q);
      check(q, exp);
      check({31'h0, hresp}, 32'h0);
   endtask : rd_chk

   // Counts edges until the done pulse, 150 means none came
   task automatic wait_irq(output int k);
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (irq !== 1'b1 && k < 150);
   endtask : wait_irq

   task automatic fire_pulse();
      fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
   endtask : fire_pulse

   // Disturbs a running conversion; address ff means a timer trigger
   task automatic abort_run(input logic [7:0] a, input ats_word_t d,
                            input ats_code_t old, input logic restart);
      repeat (20) @(posedge hclk);
      if (a == 8'hff) begin
         fire_pulse();
      end else begin
         wr(a, d);
      end
      rd_chk(OFS_RESULT_WORD, {20'h0, old});
      wait_irq(n);
      check({31'h0, n > 50}, {31'h0, restart});
   endtask : abort_run

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(OFS_RESULT_WORD, 32'h0);
      rd_chk(OFS_RESULT_HIGH, 32'h0);
      rd_chk(8'h40, 32'h0);
      // Single software conversions over the table
      foreach (rows[i]) begin
         vin_half[rows[i].ch] <= rows[i].vin;
         wr(OFS_CHAN, {28'h0, rows[i].ch});
         wr(OFS_MODE, 32'h80);
         wait_irq(n);
         check({31'h0, n < 150}, 32'h1);
         rd_chk(OFS_RESULT_WORD, {20'h0, rows[i].code});
         rd_chk(OFS_RESULT_HIGH, {24'h0, rows[i].code[11:4]});
         rd_chk(OFS_MODE, 32'h0);
      end
      // Software restarts keep the old result
      vin_half[4'ha] <= 14'd100;
      wr(OFS_MODE, 32'h80);
      abort_run(OFS_MODE, 32'h80, 12'h556, 1'b1);
      vin_half[4'ha] <= 14'd200;
      wr(OFS_MODE, 32'h80);
      abort_run(OFS_CHAN, 32'ha, 12'h032, 1'b1);
      // Continuous chain, then a stop in mid conversion
      wr(OFS_MODE, 32'hc0);
      wait_irq(n);
      wait_irq(n);
      check({31'h0, n < 100}, 32'h1);
      vin_half[4'ha] <= 14'd300;
      repeat (20) @(posedge hclk);
      wr(OFS_MODE, 32'h40);
      wait_irq(n);
      check(n, 150);
      rd_chk(OFS_RESULT_WORD, 32'h064);
      rd_chk(OFS_STATUS, 32'h0);
      // Timer single mode
      wr(OFS_MODE, 32'h00);
      wr(OFS_MODE_TWO, 32'h80);
      wait_irq(n);
      check(n, 150);
      fire_pulse();
      repeat (3) @(posedge hclk);
      rd_chk(OFS_MODE, 32'h80);
      abort_run(8'hff, 32'h0, 12'h064, 1'b1);
      rd_chk(OFS_RESULT_WORD, 32'h096);
      rd_chk(OFS_MODE, 32'h0);
      vin_half[4'ha] <= 14'd400;
      fire_pulse();
      abort_run(OFS_CHAN, 32'h3, 12'h096, 1'b0);
      rd_chk(OFS_RESULT_WORD, 32'h0c8);
      fire_pulse();
      wait_irq(n);
      rd_chk(OFS_RESULT_WORD, 32'h001);
      check({28'h0, chan}, 32'h3);
      // Timer continuous mode on the full scale channel
      wr(OFS_CHAN, 32'hf);
      wr(OFS_MODE, 32'h40);
      fire_pulse();
      wait_irq(n);
      repeat (20) @(posedge hclk);
      wr(OFS_MODE, 32'h40);
      wait_irq(n);
      check(n, 150);
      fire_pulse();
      wait_irq(n);
      check({31'h0, n < 150}, 32'h1);
      wr(OFS_MODE, 32'h40);
      wr(OFS_MODE_TWO, 32'h0);
      fire_pulse();
      wait_irq(n);
      check(n, 150);
      rd_chk(OFS_RESULT_HIGH, 32'hff);
      // Reset while the engine is idle clears the results
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(OFS_RESULT_WORD, 32'h0);
      rd_chk(OFS_RESULT_HIGH, 32'h0);
      close_out();
   end
endmodule : testbench
`default_nettype wire
